// File: rtl/flash_host_regs.svh
// Opcodes, field positions, reset values and timing counts for the flash host
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
// Operation
// - Wrap setup: opcode 77H, 24 dummy bits, one wrap byte, then deselect.
// - Wrap disable is 1 at power-on; set it again to return to linear.
// - Opcode 90H plus 24-bit address; address 1 returns device code first.
// - Opcode 92H: same identification, address and data two bits per clock.
// - Opcode 94H: four lines, address then 4 dummy clocks before data.
// - Opcode 4Bh, four dummy bytes, then a 64-bit unique number.
// - Power-down B9h needs select raised right after the eighth bit.
// - Release ABH then select held high for the release wait time.
// - Release with identification needs the longer wait before next command; here RES2_NS equals RES1_NS (3000 ns).
// - Opcode 48H, 3-byte address, one dummy byte, then incrementing data.
`define OP_WRAP 8'h77
`define OP_MFID 8'h90
`define OP_MFID_DUAL 8'h92
`define OP_MFID_QUAD 8'h94
`define OP_JEDEC 8'h9f
`define OP_UID 8'h4b
`define OP_PDOWN 8'hb9
`define OP_RELEASE 8'hab
`define OP_SECREAD 8'h48
`define WRAP_DIS_BIT 4
`define WRAP_RESET 8'h10
`define SCK_HALF 4'h6
`define CS_GAP_CYC 8'h08
`define PDOWN_ENTRY_NS 3000
`define RES1_NS 3000
`define RES2_NS 3000
`define CLK_NS 10
`endif

// File: rtl/flash_host_pkg.sv
// Types for the flash host controller
package flash_host_pkg;
   typedef enum logic [3:0] {
      CMD_WRAP, CMD_MFID, CMD_MFID_DUAL, CMD_MFID_QUAD, CMD_JEDEC,
      CMD_UID, CMD_PDOWN, CMD_RELEASE, CMD_RELEASE_ID, CMD_SECREAD
   } command_type;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SHIFT, ST_DESEL, ST_WAIT
   } state_type;
endpackage

// File: rtl/flash_host.sv
// Host controller driving a serial flash over single, dual and quad lines
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"
module flash_host #(
   parameter int ENTRY_CYC = (`PDOWN_ENTRY_NS + `CLK_NS - 1) / `CLK_NS,
   parameter int RES1_CYC = (`RES1_NS + `CLK_NS - 1) / `CLK_NS,
   parameter int RES2_CYC = (`RES2_NS + `CLK_NS - 1) / `CLK_NS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // User command port
   input wire logic cmdValid,
   output logic cmdReady,
   input wire flash_host_pkg::command_type cmdCode,
   input wire logic [23:0] cmdAddr,
   input wire logic [7:0] cmdWrap,
   input wire logic [7:0] cmdLength,
   output logic rdValid,
   output logic [7:0] rdData,
   output logic done,
   output logic powerDown,
   output logic [7:0] wrapSetting,
   // Flash pins
   output logic csN,
   output logic sck,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOeN
);
   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------
   logic [3:0] ioMeta_reg;
   logic [3:0] ioSync_reg;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ioMeta_reg <= 4'h0;
         ioSync_reg <= 4'h0;
      end else begin
         ioMeta_reg <= ioIn;
         ioSync_reg <= ioMeta_reg;
      end
   end

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   function automatic logic [7:0] opcode_of(input flash_host_pkg::command_type c);
      case (c)
         flash_host_pkg::CMD_WRAP: opcode_of = `OP_WRAP;
         flash_host_pkg::CMD_MFID: opcode_of = `OP_MFID;
         flash_host_pkg::CMD_MFID_DUAL: opcode_of = `OP_MFID_DUAL;
         flash_host_pkg::CMD_MFID_QUAD: opcode_of = `OP_MFID_QUAD;
         flash_host_pkg::CMD_JEDEC: opcode_of = `OP_JEDEC;
         flash_host_pkg::CMD_UID: opcode_of = `OP_UID;
         flash_host_pkg::CMD_PDOWN: opcode_of = `OP_PDOWN;
         flash_host_pkg::CMD_SECREAD: opcode_of = `OP_SECREAD;
         default: opcode_of = `OP_RELEASE;
      endcase
   endfunction

   // Bits moved per clock after the opcode
   function automatic logic [2:0] lanes_of(input flash_host_pkg::command_type c);
      case (c)
         flash_host_pkg::CMD_MFID_DUAL: lanes_of = 3'h2;
         flash_host_pkg::CMD_MFID_QUAD: lanes_of = 3'h4;
         default: lanes_of = 3'h1;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Control state
   // ------------------------------------------------------------
   flash_host_pkg::state_type state_reg;
   flash_host_pkg::command_type cmd_reg;
   logic [3:0] div_reg;
   logic [7:0] bitCnt_reg;
   logic [7:0] phaseEnd_reg;
   logic [39:0] shift_reg;
   logic [7:0] inByte_reg;
   logic [3:0] inBits_reg;
   logic [7:0] outLeft_reg;
   logic [15:0] wait_reg;
   logic pdown_reg;
   logic [7:0] wrap_reg;
   logic [2:0] lanes;
   logic [2:0] shiftLanes;
   logic start;
   logic [15:0] waitLimit;
   logic waitOver;
   logic rise;
   logic fall;
   logic inData;
   logic [7:0] hdrBits;

   assign lanes = (bitCnt_reg < 8'd8) ? 3'h1 : lanes_of(cmd_reg);
   // The eighth fall still drops a single opcode bit
   assign shiftLanes = (bitCnt_reg <= 8'd8) ? 3'h1 : lanes_of(cmd_reg);
   assign rise = (state_reg == flash_host_pkg::ST_SHIFT) && !sck && (div_reg == `SCK_HALF);
   assign fall = (state_reg == flash_host_pkg::ST_SHIFT) && sck && (div_reg == `SCK_HALF);
   assign inData = bitCnt_reg >= phaseEnd_reg;
   assign cmdReady = (state_reg == flash_host_pkg::ST_IDLE);
   assign start = cmdValid && cmdReady && (!pdown_reg || cmdCode == flash_host_pkg::CMD_RELEASE ||
      cmdCode == flash_host_pkg::CMD_RELEASE_ID);

   // Header length in clocks: opcode plus address and dummy phases
   always_comb begin
      case (cmdCode)
         flash_host_pkg::CMD_WRAP: hdrBits = 8'd40;
         flash_host_pkg::CMD_MFID: hdrBits = 8'd32;
         flash_host_pkg::CMD_MFID_DUAL: hdrBits = 8'd20;
         flash_host_pkg::CMD_MFID_QUAD: hdrBits = 8'd18;
         flash_host_pkg::CMD_JEDEC: hdrBits = 8'd8;
         flash_host_pkg::CMD_UID: hdrBits = 8'd40;
         flash_host_pkg::CMD_RELEASE_ID: hdrBits = 8'd32;
         flash_host_pkg::CMD_SECREAD: hdrBits = 8'd40;
         default: hdrBits = 8'd8;
      endcase
   end

   // Select-high time after each frame
   always_comb begin
      case (cmd_reg)
         flash_host_pkg::CMD_PDOWN: waitLimit = 16'(ENTRY_CYC);
         flash_host_pkg::CMD_RELEASE: waitLimit = 16'(RES1_CYC);
         flash_host_pkg::CMD_RELEASE_ID: waitLimit = 16'(RES2_CYC);
         default: waitLimit = 16'(`CS_GAP_CYC);
      endcase
   end
   assign waitOver = (state_reg == flash_host_pkg::ST_WAIT) && (wait_reg >= waitLimit);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= flash_host_pkg::ST_IDLE;
         cmd_reg <= flash_host_pkg::CMD_JEDEC;
         div_reg <= 4'h0;
         sck <= 1'b0;
         csN <= 1'b1;
         bitCnt_reg <= 8'h00;
         phaseEnd_reg <= 8'h00;
         shift_reg <= 40'h0;
         outLeft_reg <= 8'h00;
         wait_reg <= 16'h0;
      end else begin
         case (state_reg)
            flash_host_pkg::ST_IDLE: begin
               // Only release is sent while the device sleeps
               if (start) begin
                  cmd_reg <= cmdCode;
                  csN <= 1'b0;
                  div_reg <= 4'h0;
                  bitCnt_reg <= 8'h00;
                  phaseEnd_reg <= hdrBits;
                  outLeft_reg <= cmdLength;
                  if (cmdCode == flash_host_pkg::CMD_WRAP) begin
                     shift_reg <= {`OP_WRAP, 24'h0, cmdWrap};
                  end else begin
                     shift_reg <= {opcode_of(cmdCode), cmdAddr, 8'h00};
                  end
                  state_reg <= flash_host_pkg::ST_SHIFT;
               end
            end
            flash_host_pkg::ST_SHIFT: begin
               div_reg <= (div_reg == `SCK_HALF) ? 4'h0 : div_reg + 4'h1;
               if (rise) begin
                  sck <= 1'b1;
                  bitCnt_reg <= bitCnt_reg + 8'h01;
               end
               if (fall) begin
                  sck <= 1'b0;
                  if (!inData) begin
                     if (shiftLanes == 3'h4) begin
                        shift_reg <= {shift_reg[35:0], 4'h0};
                     end else if (shiftLanes == 3'h2) begin
                        shift_reg <= {shift_reg[37:0], 2'h0};
                     end else begin
                        shift_reg <= {shift_reg[38:0], 1'b0};
                     end
                  end
                  // Deselect right after the header, or after the last byte
                  if (bitCnt_reg == phaseEnd_reg && (outLeft_reg == 8'h00 ||
                        phaseEnd_reg == 8'd8 && cmd_reg != flash_host_pkg::CMD_JEDEC ||
                        cmd_reg == flash_host_pkg::CMD_WRAP)) begin
                     csN <= 1'b1;
                     wait_reg <= 16'h0;
                     state_reg <= flash_host_pkg::ST_WAIT;
                  end
                  if (inData && inBits_reg == 4'h8 && outLeft_reg == 8'h01) begin
                     csN <= 1'b1;
                     wait_reg <= 16'h0;
                     state_reg <= flash_host_pkg::ST_WAIT;
                  end
                  if (inData && inBits_reg == 4'h8 && outLeft_reg != 8'h00) begin
                     outLeft_reg <= outLeft_reg - 8'h01;
                  end
               end
            end
            flash_host_pkg::ST_WAIT: begin
               wait_reg <= wait_reg + 16'h1;
               // Hold select high for the wait the command needs
               if (waitOver) begin
                  state_reg <= flash_host_pkg::ST_IDLE;
               end
            end
            default: state_reg <= flash_host_pkg::ST_IDLE;
         endcase
      end
   end

   a_select_idle_high: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg != flash_host_pkg::ST_SHIFT) |-> csN)
      else $error("select low outside a frame");
   a_clock_low_deselected: assert property (@(posedge clock) disable iff (!reset_n)
      csN |-> !sck)
      else $error("serial clock high while deselected");
   a_pdown_select_rise: assert property (@(posedge clock) disable iff (!reset_n)
      (fall && cmd_reg == flash_host_pkg::CMD_PDOWN && bitCnt_reg == 8'd8) |=> csN)
      else $error("power-down frame not closed after eighth bit");
   a_wrap_frame_end: assert property (@(posedge clock) disable iff (!reset_n)
      (fall && cmd_reg == flash_host_pkg::CMD_WRAP && bitCnt_reg == 8'd40) |=>
      (csN && state_reg == flash_host_pkg::ST_WAIT))
      else $error("wrap frame not closed after forty clocks");
   a_release_wait_held: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == flash_host_pkg::ST_WAIT && cmd_reg == flash_host_pkg::CMD_RELEASE &&
      wait_reg < 16'(RES1_CYC)) |=> (state_reg == flash_host_pkg::ST_WAIT))
      else $error("release wait cut short");
   a_release_id_wait: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == flash_host_pkg::ST_WAIT && cmd_reg == flash_host_pkg::CMD_RELEASE_ID &&
      wait_reg < 16'(RES2_CYC)) |=> (state_reg == flash_host_pkg::ST_WAIT))
      else $error("release with identification wait cut short");

   // ------------------------------------------------------------
   // Data pins
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ioOut <= 4'h0;
         ioOeN <= 4'hf;
      end else if (state_reg != flash_host_pkg::ST_SHIFT || inData) begin
         ioOut <= 4'h0;
         ioOeN <= (state_reg == flash_host_pkg::ST_SHIFT) ? 4'hf : {3'h7, csN};
      end else if (lanes == 3'h4) begin
         ioOut <= shift_reg[39:36];
         ioOeN <= 4'h0;
      end else if (lanes == 3'h2) begin
         ioOut <= {2'h0, shift_reg[39:38]};
         ioOeN <= 4'hc;
      end else begin
         ioOut <= {3'h0, shift_reg[39]};
         ioOeN <= 4'he;
      end
   end

   a_data_lines_released: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == flash_host_pkg::ST_SHIFT && inData) |=> (ioOeN == 4'hf))
      else $error("host drives lines during data phase");
   a_quad_lines_driven: assert property (@(posedge clock) disable iff (!reset_n)
      (state_reg == flash_host_pkg::ST_SHIFT && !inData && bitCnt_reg >= 8'd8 &&
      cmd_reg == flash_host_pkg::CMD_MFID_QUAD) |=> (ioOeN == 4'h0))
      else $error("quad address not driven on four lines");

   // ------------------------------------------------------------
   // Read data capture on rising edges
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         inByte_reg <= 8'h00;
         inBits_reg <= 4'h0;
         rdValid <= 1'b0;
         rdData <= 8'h00;
      end else begin
         rdValid <= 1'b0;
         if (state_reg == flash_host_pkg::ST_IDLE) begin
            inBits_reg <= 4'h0;
         end else if (fall && inData && inBits_reg == 4'h8) begin
            inBits_reg <= 4'h0;
            rdValid <= 1'b1;
            rdData <= inByte_reg;
         end else if (rise && inData) begin
            if (lanes == 3'h4) begin
               inByte_reg <= {inByte_reg[3:0], ioSync_reg};
               inBits_reg <= inBits_reg + 4'h4;
            end else if (lanes == 3'h2) begin
               inByte_reg <= {inByte_reg[5:0], ioSync_reg[1:0]};
               inBits_reg <= inBits_reg + 4'h2;
            end else begin
               inByte_reg <= {inByte_reg[6:0], ioSync_reg[1]};
               inBits_reg <= inBits_reg + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Device mode mirror
   // ------------------------------------------------------------
   logic [7:0] wrapPend_reg;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pdown_reg <= 1'b0;
         wrap_reg <= `WRAP_RESET;
         wrapPend_reg <= `WRAP_RESET;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         // Wrap byte kept apart, the shifter is emptied by the frame
         if (start && cmdCode == flash_host_pkg::CMD_WRAP) begin
            wrapPend_reg <= cmdWrap;
         end
         if (waitOver) begin
            done <= 1'b1;
            if (cmd_reg == flash_host_pkg::CMD_PDOWN) begin
               pdown_reg <= 1'b1;
            end
            if (cmd_reg == flash_host_pkg::CMD_RELEASE ||
                  cmd_reg == flash_host_pkg::CMD_RELEASE_ID) begin
               pdown_reg <= 1'b0;
            end
            if (cmd_reg == flash_host_pkg::CMD_WRAP) begin
               wrap_reg <= wrapPend_reg & 8'h70;
            end
         end
      end
   end

   assign powerDown = pdown_reg;
   assign wrapSetting = wrap_reg;
endmodule
`default_nettype wire

// File: verification/flash_dev_model.sv
// Behavioural serial flash that answers the host controller
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
   parameter logic [7:0] MFR = 8'h5a, // Identity values are arbitrary
   parameter logic [7:0] DEV = 8'h3c,
   parameter logic [7:0] MTYPE = 8'h61,
   parameter logic [7:0] CAP = 8'h16,
   parameter int RES_CYC = 5
) (
   // Clock and flash pins
   input wire logic clock,
   input wire logic csN,
   input wire logic sck,
   input wire logic [3:0] io,
   output wire logic [3:0] devIo,
   // Busy state set by the bench
   input wire logic write_in_progress_flag,
   // Observed state
   output logic pd,
   output logic [7:0] wrapStored,
   output int early,
   output int ignored
);
   logic [7:0] dv;
   logic [7:0] op = 8'h00;
   logic [23:0] adr = 24'h000000;
   logic [7:0] wb = 8'h00;
   logic [3:0] outVal = 4'h0;
   logic [3:0] tog = 4'h5;
   logic drv = 1'b0;
   int cnt = 0;
   int w;
   int d;
   int b;
   realtime relT = -1.0e9;
   initial begin
      pd = 1'b0;
      wrapStored = 8'h10;
      early = 0;
      ignored = 0;
   end
   // Released lines toggle so they never look like held data
   assign devIo = drv ? outVal : tog;
   always @(posedge clock) tog <= ~tog;
   always_comb begin
      w = (op == 8'h92) ? 2 : (op == 8'h94) ? 4 : 1;
      case (op)
         8'h90, 8'hab: d = 32;
         8'h92: d = 20;
         8'h94: d = 18;
         8'h9f: d = 8;
         default: d = 40;
      endcase
   end
   function automatic logic [7:0] dataByte(int k);
      case (op)
         8'h9f: return (k % 3 == 0) ? MFR : (k % 3 == 1) ? MTYPE : CAP;
         8'h4b: return 8'hc0 + 8'(k % 8);
         8'hab: return DEV;
         8'h48: return (adr[7:0] + 8'(k)) ^ {adr[13:12], 6'h00};
         default: return ((k % 2) == int'(adr[0])) ? MFR : DEV;
      endcase
   endfunction
   always @(negedge csN) begin
      cnt = 0;
      if ($realtime - relT < RES_CYC * 10) early = early + 1;
   end
   always @(posedge sck) begin
      if (!csN) begin
         if (cnt < 8) op <= {op[6:0], io[0]};
         else if (op == 8'h77 && cnt >= 32) wb <= {wb[6:0], io[0]};
         else if (cnt < 8 + 24 / w) adr <= (adr << w) | 24'(io & ((4'h1 << w) - 4'h1));
         cnt = cnt + 1;
      end
   end
   always @(negedge sck) begin
      if (!csN && cnt >= d && !(pd && op != 8'hab) &&
            !(write_in_progress_flag && (op == 8'h9f || op == 8'hab))) begin
         b = (cnt - d) * w;
         dv = dataByte(b / 8) << (b % 8);
         outVal <= (w == 4) ? dv[7:4] : (w == 2) ? {2'b00, dv[7:6]} : {2'b00, dv[7], 1'b0};
         drv <= 1'b1;
      end
   end
   always @(posedge csN) begin
      drv <= 1'b0;
      if (!pd && op == 8'hb9 && cnt == 8) pd <= 1'b1;
      if (!pd && op == 8'h77 && cnt == 40) wrapStored <= wb;
      if (write_in_progress_flag && cnt >= 8 && (op == 8'h9f || op == 8'hab)) ignored = ignored + 1;
      if (pd && op == 8'hab && !write_in_progress_flag) begin
         pd <= 1'b0;
         relT = $realtime;
      end
   end
endmodule
`default_nettype wire

// File: verification/flash_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module flash_host_tb;
   localparam logic [7:0] MFR = 8'h5a;
   localparam logic [7:0] DEV = 8'h3c;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic cmdValid = 1'b0;
   flash_host_pkg::command_type cmdCode = flash_host_pkg::CMD_WRAP;
   logic [23:0] cmdAddr = 24'h000000;
   logic [7:0] cmdWrap = 8'h00;
   logic [7:0] cmdLength = 8'h00;
   logic cmdReady, rdValid, done, powerDown, csN, sck, pd;
   logic [7:0] rdData, wrapSetting, wrapStored;
   logic [3:0] ioIn, ioOut, ioOeN, devIo;
   int early;
   int ignored;
   logic write_in_progress_flag = 1'b0;
   int fails = 0;
   int n_checks = 0;
   logic [7:0] rx[$];
   flash_host_pkg::command_type ids[3] = '{flash_host_pkg::CMD_MFID,
      flash_host_pkg::CMD_MFID_DUAL, flash_host_pkg::CMD_MFID_QUAD};
   assign ioIn = (~ioOeN & ioOut) | (ioOeN & devIo);
   flash_host #(.ENTRY_CYC(5), .RES1_CYC(5), .RES2_CYC(5)) flash_host_i (.clock(clock),
      .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode),
      .cmdAddr(cmdAddr), .cmdWrap(cmdWrap), .cmdLength(cmdLength), .rdValid(rdValid),
      .rdData(rdData), .done(done), .powerDown(powerDown), .wrapSetting(wrapSetting),
      .csN(csN), .sck(sck), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));
   flash_dev_model #(.MFR(MFR), .DEV(DEV), .RES_CYC(5)) flash_dev_model_i (.clock(clock),
      .csN(csN), .sck(sck), .io(ioIn), .devIo(devIo), .pd(pd), .wrapStored(wrapStored),
      .early(early), .write_in_progress_flag(write_in_progress_flag), .ignored(ignored));
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic run(flash_host_pkg::command_type c, logic [23:0] a, logic [7:0] wv,
      logic [7:0] n);
      int t;
      int nDone = 0;
      rx.delete();
      @(posedge clock);
      while (cmdReady !== 1'b1) @(posedge clock);
      cmdCode <= c;
      cmdAddr <= a;
      cmdWrap <= wv;
      cmdLength <= n;
      cmdValid <= 1'b1;
      @(posedge clock);
      cmdValid <= 1'b0;
      for (t = 0; t < 5000; t++) begin
         @(posedge clock);
         if (rdValid === 1'b1) rx.push_back(rdData);
         if (done === 1'b1) nDone++;
         if (cmdReady === 1'b1 && csN === 1'b1) break;
      end
      chk("length", n, 8'(rx.size()));
      chk("done", 8'h01, 8'(nDone));
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #600000;
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk("wrapSetting", 8'h10, wrapSetting);
      chk("powerDown", 8'h00, powerDown);
      for (int i = 0; i < 5; i++) begin
         run(flash_host_pkg::CMD_WRAP, 24'h0, (i < 4) ? {1'b0, 2'(i), 5'h00} : 8'h10, 0);
         chk("wrapSetting", (i < 4) ? {1'b0, 2'(i), 5'h00} : 8'h10, wrapSetting);
         chk("wrapStored", (i < 4) ? {1'b0, 2'(i), 5'h00} : 8'h10, wrapStored);
      end
      $display("test wrap done");
      for (int i = 0; i < 6; i++) begin
         run(ids[i / 2], 24'(i % 2), 8'h00, 8'h02);
         chk("idFirst", (i % 2) ? DEV : MFR, rx[0]);
         chk("idSecond", (i % 2) ? MFR : DEV, rx[1]);
      end
      $display("test manufacturer id done");
      run(flash_host_pkg::CMD_JEDEC, 24'h0, 8'h00, 8'h03);
      chk("jedec", MFR, rx[0]);
      chk("jedec", 8'h61, rx[1]);
      chk("jedec", 8'h16, rx[2]);
      run(flash_host_pkg::CMD_JEDEC, 24'h0, 8'h00, 8'h01);
      chk("jedecShort", MFR, rx[0]);
      run(flash_host_pkg::CMD_UID, 24'h0, 8'h00, 8'h08);
      for (int k = 0; k < 8; k++) chk("uid", 8'hc0 + 8'(k), rx[k]);
      $display("test identity done");
      for (int r = 1; r < 4; r++) begin
         run(flash_host_pkg::CMD_SECREAD, {8'h00, 4'(r), 12'h0fe}, 8'h00, 8'h04);
         for (int k = 0; k < 4; k++) begin
            chk("secure", (8'hfe + 8'(k)) ^ {2'(r), 6'h00}, rx[k]);
         end
      end
      $display("test security register done");
      run(flash_host_pkg::CMD_PDOWN, 24'h0, 8'h00, 8'h00);
      chk("powerDown", 8'h01, powerDown);
      chk("devicePd", 8'h01, pd);
      run(flash_host_pkg::CMD_RELEASE, 24'h0, 8'h00, 8'h00);
      chk("powerDown", 8'h00, powerDown);
      chk("devicePd", 8'h00, pd);
      run(flash_host_pkg::CMD_PDOWN, 24'h0, 8'h00, 8'h00);
      run(flash_host_pkg::CMD_RELEASE_ID, 24'h0, 8'h00, 8'h02);
      chk("releaseId", DEV, rx[0]);
      chk("releaseId", DEV, rx[1]);
      run(flash_host_pkg::CMD_JEDEC, 24'h0, 8'h00, 8'h01);
      chk("jedec", MFR, rx[0]);
      chk("earlySelect", 8'h00, 8'(early));
      write_in_progress_flag <= 1'b1;
      run(flash_host_pkg::CMD_JEDEC, 24'h0, 8'h00, 8'h01);
      run(flash_host_pkg::CMD_PDOWN, 24'h0, 8'h00, 8'h00);
      run(flash_host_pkg::CMD_RELEASE, 24'h0, 8'h00, 8'h00);
      chk("devicePd", 8'h01, pd);
      chk("ignored", 8'h02, 8'(ignored));
      write_in_progress_flag <= 1'b0;
      run(flash_host_pkg::CMD_RELEASE, 24'h0, 8'h00, 8'h00);
      chk("devicePd", 8'h00, pd);
      chk("earlySelect", 8'h00, 8'(early));
      $display("test power down done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
